// [design/mwt_apb_decode.sv]
`timescale 1ns/1ps
`include "mwt_consts.svh"
module mwt_apb_decode
(
	// APB request
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	// Decoded strobes
	output logic wr_control,
	output logic wr_command,
	output logic wr_mode,
	output logic rd_status,
	output logic rd_mode,
	output logic unmapped
);
	wire logic access;
	assign access = psel && penable;
	assign wr_control = access && pwrite && (paddr == `MWT_CONTROL_ADDR);
	assign wr_command = access && pwrite && (paddr == `MWT_COMMAND_ADDR);
	assign wr_mode = access && pwrite && (paddr == `MWT_MODE_ADDR);
	assign rd_status = access && !pwrite && (paddr == `MWT_STATUS_ADDR);
	assign rd_mode = access && !pwrite && (paddr == `MWT_MODE_ADDR);
	assign unmapped = access && (paddr != `MWT_CONTROL_ADDR) && (paddr != `MWT_COMMAND_ADDR)
		&& (paddr != `MWT_STATUS_ADDR) && (paddr != `MWT_MODE_ADDR);
endmodule

// [design/mwt_binary_stage.sv]
`timescale 1ns/1ps
module mwt_binary_stage
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic clear,
	input wire logic tick,
	// Stage bit and carry
	output logic bit_q,
	output logic carry
);
	assign carry = tick && bit_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bit_q <= 1'b0;
		else if (clear)
			bit_q <= 1'b0;
		else if (tick)
			bit_q <= !bit_q;
	end
endmodule

// [design/mwt_consts.svh]
`ifndef MWT_CONSTS_SVH
`define MWT_CONSTS_SVH

// Register word indices and byte offsets
`define MWT_CONTROL_IDX 8'h34
`define MWT_COMMAND_IDX 8'h35
`define MWT_CONTROL_ADDR 12'h0d0
`define MWT_COMMAND_ADDR 12'h0d4
`define MWT_STATUS_ADDR 12'h0d8
`define MWT_MODE_ADDR 12'h0dc

// Control register fields
`define MWT_BIT_OUTSEL 0
`define MWT_BIT_TIME_LO 1
`define MWT_BIT_TIME_HI 2
`define MWT_BIT_ENABLE 3
`define MWT_BIT_TRAP_ACT 4
`define MWT_BIT_TRAP_AREA 5

// Mode register fields
`define MWT_BIT_DIVSEL 0
`define MWT_BIT_SLOW 1
`define MWT_BIT_STOP 2
`define MWT_BIT_IDLE 3
`define MWT_BIT_FS_TICK 4

// Command codes
`define MWT_CODE_CLEAR 8'h4e
`define MWT_CODE_DISABLE 8'hb1
`define MWT_CODE_TRAP 8'hd2

// Reset values
`define MWT_CONTROL_RESET 6'h39
`define MWT_MODE_RESET 5'h00

// Prescaler width: low-order divider in front of the binary counter
`define MWT_PRE_W 25
// Reset pulse: 24 high-frequency periods, taken as 24 pclk at most
`define MWT_RST_NS 192
`define MWT_CLK_NS 8
`define MWT_RST_CYC ((`MWT_RST_NS) / (`MWT_CLK_NS))

`endif

// [design/mwt_pkg.sv]
package mwt_pkg;

	typedef struct packed {
		logic trap_area_select;
		logic trap_action_select;
		logic wd_enable_bit;
		logic [1:0] detection_time_select;
		logic overflow_action_select;
	} mwt_control_t;

	typedef struct packed {
		logic fs_tick;
		logic idle_sleep;
		logic stop;
		logic slow;
		logic divider_clock_select;
	} mwt_mode_t;

	typedef enum logic [1:0] {
		MWT_RUN = 2'b00,
		MWT_RST = 2'b01,
		MWT_OFF = 2'b11
	} mwt_state_t;

endpackage

// [design/mwt_watchdog.sv]
// Operation
// RULE_01 - Reset selects reset-request on overflow
// RULE_02 - Interrupt selection locks until reset
// RULE_03 - Enable bit resets to one
// RULE_04 - Overflow with select one: reset request
// RULE_05 - Overflow with select zero: interrupt
// RULE_06 - Hold count in stop, idle, sleep
// RULE_07 - Prescaler plus two-stage counter; 4EH clears
// RULE_08 - Software clears within three quarters time
// RULE_09 - Control register one bit layout
// RULE_10 - Detection time code selects prescaler tap
// RULE_11 - Control register write-only, no RMW
// RULE_12 - Command decodes 4EH, B1H, D2H only
// RULE_13 - Disable code needs enable bit zero
// RULE_14 - Software stop sequence is fixed
// RULE_15 - Disabled watchdog holds counter cleared
// RULE_16 - Software clears around stop mode
// RULE_17 - No counter clear inside interrupts
// RULE_18 - Periodic interrupt timer use allowed
// RULE_19 - Overflow reset lasts 24 clocks at most
// RULE_20 - Watchdog interrupt is non-maskable
// RULE_21 - Trap bits stored and passed out
// RULE_22 - Prescaler source from divider select, mode
`timescale 1ns/1ps
`include "mwt_consts.svh"
module mwt_watchdog
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Watchdog outputs
	output logic watchdog_interrupt_request,
	output logic reset_request,
	output logic reset_pin_n,
	// Address-trap side
	output logic trap_area_select,
	output logic trap_action_select,
	output logic trap_area_commit
);
	mwt_pkg::mwt_control_t control;
	mwt_pkg::mwt_control_t next_control;
	mwt_pkg::mwt_mode_t mode;
	mwt_pkg::mwt_state_t state;
	mwt_pkg::mwt_state_t next_state;
	logic out_locked;
	logic [`MWT_PRE_W-1:0] prescaler;
	logic [4:0] rst_count;
	logic overflow_seen;

	wire logic wr_control;
	wire logic wr_command;
	wire logic wr_mode;
	wire logic rd_status;
	wire logic rd_mode;
	wire logic unmapped;
	wire logic [7:0] code;
	wire logic cmd_clear;
	wire logic cmd_disable;
	wire logic cmd_trap;
	wire logic paused;
	wire logic use_fast;
	wire logic pre_tick;
	wire logic [`MWT_PRE_W-1:0] next_prescaler;
	wire logic fs_step;
	wire logic [4:0] tap;
	wire logic stage_tick;
	wire logic stage0_q;
	wire logic stage0_carry;
	wire logic stage1_q;
	wire logic overflow;
	wire logic counter_clear;
	wire logic running;

	mwt_apb_decode u_decode
	(
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.wr_control(wr_control),
		.wr_command(wr_command),
		.wr_mode(wr_mode),
		.rd_status(rd_status),
		.rd_mode(rd_mode),
		.unmapped(unmapped)
	);

	// RULE_12 decode command codes
	assign code = pwdata[7:0];
	assign cmd_clear = wr_command && (code == `MWT_CODE_CLEAR);
	assign cmd_trap = wr_command && (code == `MWT_CODE_TRAP);
	// RULE_13 disable needs enable low
	assign cmd_disable = wr_command && (code == `MWT_CODE_DISABLE) && !control.wd_enable_bit;

	// RULE_06 pause in low-power modes
	assign paused = mode.stop || mode.idle_sleep;
	assign running = (state == mwt_pkg::MWT_RUN);

	// RULE_22 prescaler source select
	assign use_fast = !mode.slow && !mode.divider_clock_select;
	assign fs_step = mode.fs_tick;
	assign pre_tick = running && !paused && (use_fast || fs_step);
	assign next_prescaler = prescaler + {{(`MWT_PRE_W-1){1'b0}}, 1'b1};

	// RULE_10 detection time tap
	assign tap = use_fast ? (5'd22 - {2'b00, control.detection_time_select, 1'b0})
		: (5'd14 - {2'b00, control.detection_time_select, 1'b0});

	// RULE_07 counter steps on prescaler tap carry
	assign stage_tick = pre_tick && (prescaler[tap +: 1] == 1'b1)
		&& ((prescaler & ((`MWT_PRE_W'(1) << tap) - `MWT_PRE_W'(1))) == {`MWT_PRE_W{1'b1}}
		>> (`MWT_PRE_W - tap));

	// RULE_07 clear code hits binary stages only
	// RULE_15 disabled holds stages cleared
	assign counter_clear = cmd_clear || (state == mwt_pkg::MWT_OFF) || !running;

	mwt_binary_stage u_stage0
	(
		.pclk(pclk),
		.presetn(presetn),
		.clear(counter_clear),
		.tick(stage_tick),
		.bit_q(stage0_q),
		.carry(stage0_carry)
	);

	mwt_binary_stage u_stage1
	(
		.pclk(pclk),
		.presetn(presetn),
		.clear(counter_clear),
		.tick(stage0_carry),
		.bit_q(stage1_q),
		.carry(overflow)
	);

	// Control register update
	always_comb
	begin
		next_control = control;
		if (wr_control)
		begin
			next_control.trap_area_select = pwdata[`MWT_BIT_TRAP_AREA];
			next_control.trap_action_select = pwdata[`MWT_BIT_TRAP_ACT];
			next_control.wd_enable_bit = pwdata[`MWT_BIT_ENABLE];
			next_control.detection_time_select = pwdata[`MWT_BIT_TIME_HI:`MWT_BIT_TIME_LO];
			// RULE_02 interrupt choice is one-way
			next_control.overflow_action_select = pwdata[`MWT_BIT_OUTSEL] && !out_locked;
		end
		if (cmd_clear && !control.wd_enable_bit)
			next_control.wd_enable_bit = control.wd_enable_bit;
	end

	// Watchdog state
	always_comb
	begin
		next_state = state;
		case (state)
			mwt_pkg::MWT_RUN:
			begin
				if (cmd_disable)
					next_state = mwt_pkg::MWT_OFF;
				// RULE_04 overflow to reset
				else if (overflow && control.overflow_action_select)
					next_state = mwt_pkg::MWT_RST;
			end
			mwt_pkg::MWT_RST:
			begin
				// RULE_19 bounded reset pulse
				if (rst_count == 5'(`MWT_RST_CYC - 1))
					next_state = mwt_pkg::MWT_RUN;
			end
			mwt_pkg::MWT_OFF:
			begin
				if (wr_control && pwdata[`MWT_BIT_ENABLE])
					next_state = mwt_pkg::MWT_RUN;
			end
			default:
				next_state = mwt_pkg::MWT_RUN;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// RULE_01 reset request selected
			// RULE_03 enable set at reset
			// RULE_09 control bit layout
			control <= mwt_pkg::mwt_control_t'(`MWT_CONTROL_RESET);
			out_locked <= 1'b0;
			state <= mwt_pkg::MWT_RUN;
			mode <= mwt_pkg::mwt_mode_t'(`MWT_MODE_RESET);
		end
		else
		begin
			control <= next_control;
			if (wr_control && !pwdata[`MWT_BIT_OUTSEL])
				out_locked <= 1'b1;
			state <= next_state;
			if (wr_mode)
				mode <= mwt_pkg::mwt_mode_t'(pwdata[4:0]);
		end
	end

	// Prescaler counts on pre_tick only; clear code does not touch it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prescaler <= '0;
		else if (pre_tick)
			prescaler <= next_prescaler;
	end

	// RULE_19 reset pulse length
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rst_count <= 5'd0;
		else if (state == mwt_pkg::MWT_RST)
			rst_count <= rst_count + 5'd1;
		else
			rst_count <= 5'd0;
	end

	// Outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			watchdog_interrupt_request <= 1'b0;
			reset_request <= 1'b0;
			reset_pin_n <= 1'b1;
			trap_area_select <= 1'b0;
			trap_action_select <= 1'b0;
			trap_area_commit <= 1'b0;
			overflow_seen <= 1'b0;
		end
		else
		begin
			// RULE_05 overflow to interrupt
			// RULE_18 periodic interrupt on each overflow
			// RULE_20 not gated by any mask
			watchdog_interrupt_request <= overflow && !control.overflow_action_select && running;
			reset_request <= (next_state == mwt_pkg::MWT_RST);
			reset_pin_n <= !(next_state == mwt_pkg::MWT_RST);
			// RULE_21 trap bits passed out
			trap_area_select <= next_control.trap_area_select;
			trap_action_select <= next_control.trap_action_select;
			trap_area_commit <= cmd_trap;
			if (overflow)
				overflow_seen <= 1'b1;
			else if (rd_status)
				overflow_seen <= 1'b0;
		end
	end

	// APB answer: zero wait states
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && (paddr != `MWT_CONTROL_ADDR) && (paddr != `MWT_COMMAND_ADDR)
				&& (paddr != `MWT_STATUS_ADDR) && (paddr != `MWT_MODE_ADDR);
			// RULE_11 control reads as zero
			if (psel && !penable && !pwrite && (paddr == `MWT_STATUS_ADDR))
				prdata <= {26'h000_0000, overflow_seen, running, state == mwt_pkg::MWT_OFF, 1'b0,
					stage1_q, stage0_q};
			else if (psel && !penable && !pwrite && (paddr == `MWT_MODE_ADDR))
				prdata <= {27'h000_0000, mode};
			else
				prdata <= 32'h0000_0000;
		end
	end

	wire logic unused_ok;
	assign unused_ok = rd_mode | unmapped;
endmodule

// [tb/mwt_watchdog_sva.sv]
`timescale 1ns/1ps
module mwt_watchdog_sva
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Watchdog and trap outputs
	input wire logic watchdog_interrupt_request,
	input wire logic reset_request,
	input wire logic reset_pin_n,
	input wire logic trap_area_select,
	input wire logic trap_action_select,
	input wire logic trap_area_commit
);
	logic [5:0] run_len;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			run_len <= 6'h00;
		else
			run_len <= reset_request ? run_len + 6'h01 : 6'h00;
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_ctl_wr;
		psel && penable && pready && pwrite && paddr == 12'h0d0;
	endsequence
	sequence s_trap_wr;
		psel && penable && pready && pwrite && paddr == 12'h0d4 && pwdata[7:0] == 8'hd2;
	endsequence
	chk_pin_inverse: assert property (reset_pin_n == !reset_request)
		else $error("reset pin differs from request");
	chk_irq_excl: assert property (!(watchdog_interrupt_request && reset_request))
		else $error("interrupt and reset together");
	chk_rst_width: assert property ($fell(reset_request) |-> run_len == 6'h18)
		else $error("reset pulse length wrong");
	chk_rst_cap: assert property (run_len <= 6'h18)
		else $error("reset pulse too long");
	chk_irq_pulse: assert property ($rose(watchdog_interrupt_request) |=> !watchdog_interrupt_request)
		else $error("interrupt not one cycle");
	chk_ready_next: assert property (s_setup |=> pready ##1 !pready)
		else $error("ready timing wrong");
	chk_ctl_read: assert property (pready && !pwrite && paddr == 12'h0d0 |-> prdata == 32'h0000_0000)
		else $error("control read not zero");
	chk_trap_bits: assert property (s_ctl_wr |=> trap_area_select == $past(pwdata[5]))
		else $error("trap area bit not stored");
	chk_trap_act: assert property (s_ctl_wr |=> trap_action_select == $past(pwdata[4]))
		else $error("trap action bit not stored");
	chk_trap_commit: assert property (s_trap_wr |=> trap_area_commit)
		else $error("trap commit missing");
endmodule
bind mwt_watchdog mwt_watchdog_sva chk (.*);

// [tb/tb_mwt_watchdog.sv]
`timescale 1ns/1ps
module tb_mwt_watchdog;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, watchdog_interrupt_request, reset_request, reset_pin_n;
	logic trap_area_select, trap_action_select, trap_area_commit;
	int n_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	int c;
	logic [31:0] rd;
	logic err;
	mwt_watchdog dut
	(
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.watchdog_interrupt_request(watchdog_interrupt_request),
		.reset_request(reset_request),
		.reset_pin_n(reset_pin_n),
		.trap_area_select(trap_area_select),
		.trap_action_select(trap_action_select),
		.trap_area_commit(trap_area_commit)
	);
	initial
	begin
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			n_errors++;
			stop_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic rst();
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		// Answer taken at the edge where pready is sampled high
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Wait for an overflow event, at most mx cycles
	task automatic wt(input int mx);
		c = 0;
		@(negedge pclk);
		while (watchdog_interrupt_request !== 1'b1 && reset_request !== 1'b1 && c < mx)
		begin
			@(negedge pclk);
			c++;
		end
	endtask
	task automatic t_reset();
		apb(0, 12'h0d8, 0);
		chk("status", rd & 32'h0000_001b, 32'h0000_0010);
		apb(0, 12'h0d0, 0);
		chk("control read", rd, 0);
		apb(0, 12'hffc, 0);
		chk("unmapped err", {rd[30:0], err}, 1);
		$display("test reset done");
	endtask
	task automatic t_rst_ovf();
		apb(1, 12'h0dc, 8'h12);
		apb(1, 12'h0d0, 8'h0f);
		wt(2200);
		chk("reset req", reset_request, 1);
		chk("ovf window", c >= 1500 && c <= 2060, 1);
		c = 0;
		while (reset_request === 1'b1 && c < 40)
		begin
			@(negedge pclk);
			c++;
		end
		chk("reset len", c, 24);
		rst();
		$display("test reset overflow done");
	endtask
	task automatic t_irq();
		apb(1, 12'h0dc, 8'h12);
		apb(1, 12'h0d0, 8'h0e);
		wt(2200);
		chk("irq", {watchdog_interrupt_request, reset_request}, 2'b10);
		apb(1, 12'h0d0, 8'h0f);
		apb(1, 12'h0d4, 8'h4e);
		wt(2200);
		chk("irq locked", {watchdog_interrupt_request, reset_request}, 2'b10);
		$display("test interrupt done");
	endtask
	task automatic t_clear();
		// clears come from main flow only
		repeat (5)
		begin
			apb(1, 12'h0d4, 8'h4e);
			wt(1000);
			chk("cleared", c, 1000);
		end
		$display("test clear done");
	endtask
	task automatic t_hold();
		logic [1:0] s1;
		apb(1, 12'h0d4, 8'h4e);
		wt(1200);
		apb(1, 12'h0dc, 8'h16);
		apb(0, 12'h0d8, 0);
		s1 = rd[1:0];
		wt(3000);
		chk("stop hold", c, 3000);
		apb(1, 12'h0dc, 8'h1a);
		wt(3000);
		chk("idle hold", c, 3000);
		apb(0, 12'h0d8, 0);
		chk("stages kept", rd[1:0], s1);
		apb(1, 12'h0dc, 8'h12);
		wt(1100);
		chk("resumed", watchdog_interrupt_request, 1);
		$display("test hold done");
	endtask
	task automatic t_disable();
		apb(1, 12'h0d4, 8'hb1);
		apb(0, 12'h0d8, 0);
		chk("early disable", rd[3], 0);
		apb(1, 12'h0d4, 8'h4e);
		apb(1, 12'h0d0, 8'h06);
		apb(1, 12'h0d4, 8'hb1);
		apb(0, 12'h0d8, 0);
		chk("disabled", rd[3:0], 4'h8);
		apb(1, 12'h0dc, 8'h16);
		wt(3000);
		chk("no overflow", c, 3000);
		apb(1, 12'h0dc, 8'h12);
		apb(1, 12'h0d0, 8'h3e);
		apb(1, 12'h0d4, 8'hd2);
		chk("trap bits", {trap_area_select, trap_action_select}, 2'b11);
		$display("test disable done");
	endtask
	initial
	begin
		rst();
		t_reset();
		t_rst_ovf();
		t_irq();
		t_clear();
		t_hold();
		t_disable();
		stop_test();
	end
endmodule
